// *** feic_pkg.sv ***
// Package: offsets, fields, keys and timing for the flash erase interlock
// Function
// - Each code flash control register shows a read-only busy bit 11.
// - Data flash control register shows a read-only busy bit 11.
// - Code flash page wipe bit 9 erases selected page if key loaded, on code arrays 0 and 1 only.
// - Code flash array wipe bit 8 erases whole array if key loaded, on code arrays 0 and 1 only.
// - Data flash page wipe bit 9 erases the page named by its index.
// - Data flash array wipe bit 8 erases the whole data array.
// - Code flash page index is 5-bit read/write, reset zero.
// - Data flash page index is 6-bit read/write, reset zero.
// - Code flash bit 10 selects test area when set, main array when clear.
// - Without the matching key the device refuses to start the cycle.
// - Unlock word clears to zero when a write or erase completes, unless software writes it in that cycle.
package feic_pkg;
  localparam int ADDR_W = 40;
  localparam logic [ADDR_W-1:0] OFS_CODE0  = 40'hff_ffff_fe90;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 40'hff_ffff_fe94;
  localparam logic [ADDR_W-1:0] OFS_KEY    = 40'hff_ffff_fe98;
  localparam logic [ADDR_W-1:0] OFS_CODE1  = 40'hff_ffff_fe9c;
  localparam logic [ADDR_W-1:0] OFS_CODE2  = 40'hff_ffff_fea0;
  localparam logic [ADDR_W-1:0] OFS_CODE3  = 40'hff_ffff_fea4;
  localparam int BIT_BUSY   = 11;
  localparam int BIT_TEST   = 10;
  localparam int BIT_PAGE   = 9;
  localparam int BIT_MASS   = 8;
  localparam int CODE_SEL_W = 5;
  localparam int DATA_SEL_W = 6;
  localparam logic [31:0] KEY_RST  = 32'h0000_0000;
  localparam logic [31:0] KEY_ONE  = 32'h42dc_157e;
  localparam logic [31:0] KEY_TWO  = 32'h6c97_d0c5;
  localparam logic [31:0] NO_KEY   = 32'hffff_ffff;
  localparam int CLK_MHZ     = 100;
  localparam int PAGE_US     = 20;
  localparam int MASS_US     = 200;
  localparam int WRITE_US    = 1;
  localparam int PAGE_CYC    = PAGE_US * CLK_MHZ;
  localparam int MASS_CYC    = MASS_US * CLK_MHZ;
  localparam int WRITE_CYC   = WRITE_US * CLK_MHZ;
  localparam int CNT_W       = 16;
  typedef enum logic [1:0] {FEIC_OP_NONE, FEIC_OP_PAGE, FEIC_OP_MASS,
                            FEIC_OP_WRITE} feic_op_t;
endpackage

// *** feic_ctl_if.sv ***
// Interface between the register file and one array sequencer
`timescale 1ns/1ps
interface feic_ctl_if;
  import feic_pkg::*;
  logic     start;
  feic_op_t op;
  logic     busy;
  logic     done;
  modport regs (output start, output op, input busy, input done);
  modport seq  (input start, input op, output busy, output done);
endinterface : feic_ctl_if

// *** feic_seq.sv ***
// Timed erase or write sequencer for one flash array
`timescale 1ns/1ps
module feic_seq
  import feic_pkg::*;
#(
  parameter int PAGE_CYCLES  = PAGE_CYC,
  parameter int MASS_CYCLES  = MASS_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Control
  feic_ctl_if.seq   ctl
);
  typedef enum logic {S_IDLE, S_RUN} feic_state_t;
  typedef struct packed {
    feic_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } feic_seq_t;
  feic_seq_t r, next_r;

  function automatic logic [CNT_W-1:0] len(input feic_op_t o);
    case (o)
      FEIC_OP_PAGE: len = CNT_W'(PAGE_CYCLES - 1);
      FEIC_OP_MASS: len = CNT_W'(MASS_CYCLES - 1);
      default:      len = CNT_W'(WRITE_CYCLES - 1);
    endcase
  endfunction

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      S_IDLE: begin
        if (ctl.start) begin
          next_r.state = S_RUN;
          next_r.cnt   = len(ctl.op);
        end
      end
      S_RUN: begin
        if (r.cnt == '0) begin
          next_r.state = S_IDLE;
          next_r.done  = 1'b1;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      default: next_r.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '{state: S_IDLE, cnt: '0, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Busy also covers the done cycle so the request clears with it
  assign ctl.busy = (r.state == S_RUN) || r.done;
  assign ctl.done = r.done;
endmodule // feic_seq

// *** feic_top.sv ***
// Flash erase interlock control with Avalon-MM register slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module feic_top
  import feic_pkg::*;
#(
  parameter int N_CODE       = 4,
  parameter int PAGE_CYCLES  = PAGE_CYC,
  parameter int MASS_CYCLES  = MASS_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  // Clock and reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              RSTN_I,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  output logic      [1:0]        AVS_RESPONSE_O,
  // Array write requests from the flash data path
  input  wire logic [N_CODE:0]   WRITE_REQ_I,
  // Array side
  output logic      [N_CODE:0]   ARRAY_BUSY_O,
  output logic      [N_CODE-1:0] TEST_AREA_SELECT_O,
  output logic      [N_CODE:0]   WRITE_ACCEPT_O
);
  // Index N_CODE is the data array, lower indices the code arrays
  localparam int NA = N_CODE + 1;

  typedef struct packed {
    logic [NA-1:0]                 page_req;
    logic [NA-1:0]                 mass_req;
    logic [NA-1:0][DATA_SEL_W-1:0] sel;
    logic [N_CODE-1:0]             test_area;
    logic [31:0]                   key;
    logic                          ack;
    logic [31:0]                   rdata;
    logic [1:0]                    resp;
    logic [NA-1:0]                 wr_acc;
  } feic_regs_t;
  feic_regs_t r, next_r;

  feic_ctl_if ctl [NA] ();
  logic [NA-1:0] busy;
  logic [NA-1:0] done;
  logic [NA-1:0] start;
  feic_op_t      op [NA];

  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_arr
      assign ctl[g].start = start[g];
      assign ctl[g].op    = op[g];
      assign busy[g]      = ctl[g].busy;
      assign done[g]      = ctl[g].done;
      feic_seq #(
        .PAGE_CYCLES  (PAGE_CYCLES),
        .MASS_CYCLES  (MASS_CYCLES),
        .WRITE_CYCLES (WRITE_CYCLES)
      ) u_seq (
        .clk_i  (SYS_CLK_I),
        .rstn_i (RSTN_I),
        .ctl    (ctl[g])
      );
    end
  endgenerate

  // Array index addressed, or -1 for the key or unmapped
  function automatic int arr_of(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CODE0: arr_of = 0;
      OFS_CODE1: arr_of = (N_CODE > 1) ? 1 : -1;
      OFS_CODE2: arr_of = (N_CODE > 2) ? 2 : -1;
      OFS_CODE3: arr_of = (N_CODE > 3) ? 3 : -1;
      OFS_DATA:  arr_of = N_CODE;
      default:   arr_of = -1;
    endcase
  endfunction

  // Key match per array; code arrays beyond the second can never be unlocked
  function automatic logic key_ok(input int i, input logic [31:0] k);
    if (i == N_CODE || i == 0) begin
      key_ok = (k == KEY_ONE);
    end else if (i == 1) begin
      key_ok = (k == KEY_TWO);
    end else begin
      key_ok = 1'b0;
    end
  endfunction

  // Merge written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  logic        req;
  int          ai;
  logic [31:0] cur;
  logic [31:0] nw;

  always_comb begin
    next_r        = r;
    next_r.ack    = 1'b0;
    next_r.wr_acc = '0;
    start         = '0;
    ai            = arr_of(AVS_ADDRESS_I);
    cur           = 32'h0000_0000;
    nw            = 32'h0000_0000;
    req           = (AVS_READ_I || AVS_WRITE_I) && !r.ack;
    for (int i = 0; i < NA; i++) begin
      op[i] = FEIC_OP_NONE;
    end
    // Sequencer completions retire requests and wipe the key
    for (int i = 0; i < NA; i++) begin
      if (done[i]) begin
        next_r.page_req[i] = 1'b0;
        next_r.mass_req[i] = 1'b0;
        next_r.key         = KEY_RST;
      end
    end
    // Current view of the addressed control register
    if (ai >= 0) begin
      cur[BIT_BUSY] = busy[ai];
      cur[BIT_PAGE] = r.page_req[ai];
      cur[BIT_MASS] = r.mass_req[ai];
      if (ai == N_CODE) begin
        cur[DATA_SEL_W-1:0] = r.sel[ai];
      end else begin
        cur[CODE_SEL_W-1:0] = r.sel[ai][CODE_SEL_W-1:0];
        cur[BIT_TEST]       = r.test_area[ai];
      end
    end
    // Register access, one wait state then ack with data
    if (req) begin
      next_r.ack   = 1'b1;
      next_r.resp  = 2'b00;
      next_r.rdata = cur;
      if (AVS_ADDRESS_I == OFS_KEY) begin
        next_r.rdata = r.key;
      end else if (ai < 0) begin
        next_r.resp = 2'b11;
      end
    end
    // Writes land only at the edge where waitrequest is seen low
    if (AVS_WRITE_I && r.ack) begin
      nw = merge(cur, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      if (ai >= 0) begin
        if (ai == N_CODE) begin
          next_r.sel[ai] = nw[DATA_SEL_W-1:0];
        end else begin
          next_r.sel[ai] = {1'b0, nw[CODE_SEL_W-1:0]};
          next_r.test_area[ai] = nw[BIT_TEST];
        end
        // A request is only taken when idle and with the right key
        if (!busy[ai] && (nw[BIT_PAGE] || nw[BIT_MASS])) begin
          if (key_ok(ai, r.key)) begin
            next_r.page_req[ai] = nw[BIT_PAGE] && !nw[BIT_MASS];
            next_r.mass_req[ai] = nw[BIT_MASS];
            start[ai] = 1'b1;
            op[ai] = nw[BIT_MASS] ? FEIC_OP_MASS : FEIC_OP_PAGE;
          end
        end
      end else if (AVS_ADDRESS_I == OFS_KEY) begin
        // Software key wins over a completion wipe in the same cycle
        next_r.key = merge(r.key, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end
    // Data path writes, refused while busy or without key
    for (int i = 0; i < NA; i++) begin
      if (WRITE_REQ_I[i] && !busy[i] && !start[i] &&
          key_ok(i, r.key)) begin
        start[i]         = 1'b1;
        op[i]            = FEIC_OP_WRITE;
        next_r.wr_acc[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign AVS_WAITREQUEST_O  = !r.ack;
  assign AVS_READDATA_O     = r.rdata;
  assign AVS_RESPONSE_O     = r.resp;
  assign ARRAY_BUSY_O       = busy;
  assign TEST_AREA_SELECT_O = r.test_area;
  assign WRITE_ACCEPT_O     = r.wr_acc;
endmodule // feic_top

// *** feic_top_properties.sv ***
// Bus timing and busy checks for the flash erase interlock
`timescale 1ns/1ps
module feic_top_properties
  import feic_pkg::*;
#(
  parameter int N_CODE       = 4,
  parameter int MASS_CYCLES  = MASS_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  // Clock and reset
  input  wire logic            SYS_CLK_I,
  input  wire logic            RSTN_I,
  // Bus
  input  wire logic            AVS_READ_I,
  input  wire logic            AVS_WRITE_I,
  input  wire logic [31:0]     AVS_READDATA_O,
  input  wire logic            AVS_WAITREQUEST_O,
  input  wire logic [1:0]      AVS_RESPONSE_O,
  // Array side
  input  wire logic [N_CODE:0] WRITE_REQ_I,
  input  wire logic [N_CODE:0] ARRAY_BUSY_O,
  input  wire logic [N_CODE:0] WRITE_ACCEPT_O
);
  // Slack of one cycle on the longest cycle
  localparam int BMIN = WRITE_CYCLES + 1;
  localparam int BMAX = MASS_CYCLES + 2;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Cycles code array 0 has been busy; long erases exceed any delay range
  logic [31:0] busy_run;
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      busy_run <= '0;
    end else begin
      busy_run <= ARRAY_BUSY_O[0] ? busy_run + 32'h0000_0001 : '0;
    end
  end
  a_bus_answer: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("answer late");
  a_answer_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer too long");
  a_unmapped_zero: assert property (!AVS_WAITREQUEST_O &&
    AVS_RESPONSE_O == 2'b11 |-> AVS_READDATA_O == 32'h0000_0000)
    else $error("unmapped data");
  a_code_hold: assert property ($rose(ARRAY_BUSY_O[0]) |->
    ARRAY_BUSY_O[0] [*3]) else $error("code busy short");
  a_code_end: assert property (ARRAY_BUSY_O[0] |->
    busy_run < BMAX) else $error("code busy stuck");
  a_code_len: assert property (!ARRAY_BUSY_O[0] && busy_run != '0 |->
    busy_run >= BMIN) else $error("code cycle short");
  a_data_hold: assert property ($rose(ARRAY_BUSY_O[N_CODE]) |->
    ARRAY_BUSY_O[N_CODE] [*3]) else $error("data busy short");
  a_locked_array: assert property (!ARRAY_BUSY_O[2] &&
    !ARRAY_BUSY_O[3]) else $error("locked array started");
  a_accept_cause: assert property (WRITE_ACCEPT_O[0] |->
    $past(WRITE_REQ_I[0]) && !$past(ARRAY_BUSY_O[0]))
    else $error("accept without request");
  a_accept_busy: assert property (WRITE_ACCEPT_O[N_CODE] |->
    ARRAY_BUSY_O[N_CODE] ##1 !WRITE_ACCEPT_O[N_CODE])
    else $error("accept without busy");
  c_code_done: cover property ($fell(ARRAY_BUSY_O[0]));
  c_data_write: cover property (WRITE_ACCEPT_O[N_CODE]);
  c_unmapped: cover property (AVS_RESPONSE_O == 2'b11);
endmodule : feic_top_properties

bind feic_top feic_top_properties #(
  .N_CODE(N_CODE), .MASS_CYCLES(MASS_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_RESPONSE_O(AVS_RESPONSE_O),
  .WRITE_REQ_I(WRITE_REQ_I), .ARRAY_BUSY_O(ARRAY_BUSY_O),
  .WRITE_ACCEPT_O(WRITE_ACCEPT_O)
);

// *** tb_flash_erase_interlock_control.sv ***
// Register, interlock and write-cycle bench for the flash erase interlock
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_flash_erase_interlock_control;
  import feic_pkg::*;
  logic              clk = 0;
  logic              rstn = 0;
  logic              rd = 0;
  logic              wr = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0]       wd = '0;
  logic [31:0]       rdata;
  logic [31:0]       q;
  logic [4:0]        wreq = '0;
  logic [4:0]        busy;
  logic [4:0]        acc;
  logic [3:0]        tsel;
  logic [3:0]        be = 4'hf;
  logic              wq;
  logic [1:0]        rsp;
  logic [1:0]        r;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cyc = 0;

  // Short counts keep the run brief
  feic_top #(.PAGE_CYCLES(4), .MASS_CYCLES(8), .WRITE_CYCLES(2)) uut (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq), .AVS_RESPONSE_O(rsp),
    .WRITE_REQ_I(wreq), .ARRAY_BUSY_O(busy), .TEST_AREA_SELECT_O(tsel),
    .WRITE_ACCEPT_O(acc));

  initial forever #5 clk = ~clk;

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  // Held until waitrequest is seen low; data taken at that edge
  task automatic bus(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdata;
    r = rsp;
    rd <= 0;
    wr <= 0;
  endtask

  task automatic wait_idle(input int i);
    repeat (30) if (busy[i] === 1'b1) @(posedge clk);
    `CHK(busy[i], 1'b0)
  endtask

  task automatic pulse(input int i, input logic e);
    @(posedge clk);
    wreq <= 5'h01 << i;
    @(posedge clk);
    wreq <= '0;
    #1 `CHK(acc[i], e)
  endtask

  // Key, request, then busy view, completion view and key view
  task automatic op(input logic [ADDR_W-1:0] a, input logic [31:0] k,
                    input logic [11:0] v, input int i, input bit ok);
    bus(OFS_KEY, 1, k);
    bus(a, 1, {20'h0_0000, v});
    bus(a, 0, 0);
    `CHK(q, {20'h0_0000, ok ? v | 12'h800 : v & 12'hcff})
    if (ok) wait_idle(i);
    bus(a, 0, 0);
    `CHK(q, {20'h0_0000, v & 12'hcff})
    bus(OFS_KEY, 0, 0);
    `CHK(q, ok ? 32'h0000_0000 : k)
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    bus(OFS_CODE0, 0, 0);
    `CHK(q, 32'h0000_0000)
    bus(OFS_DATA, 0, 0);
    `CHK(q, 32'h0000_0000)
    op(OFS_CODE0, NO_KEY, 12'h71f, 0, 0);
    `CHK(tsel[0], 1'b1)
    op(OFS_DATA, KEY_RST, 12'h33f, 4, 0);
    op(OFS_CODE0, KEY_ONE, 12'h205, 0, 1);
    op(OFS_CODE0, KEY_ONE, 12'h10a, 0, 1);
    op(OFS_DATA, KEY_ONE, 12'h22a, 4, 1);
    op(OFS_DATA, KEY_ONE, 12'h100, 4, 1);
    op(OFS_CODE1, KEY_TWO, 12'h203, 1, 1);
    op(OFS_CODE1, KEY_ONE, 12'h100, 1, 0);
    op(OFS_CODE2, KEY_ONE, 12'h200, 2, 0);
    // Low lanes only: upper half of the loaded key survives
    be <= 4'h3;
    bus(OFS_KEY, 1, 32'h0000_0000);
    be <= 4'hf;
    bus(OFS_KEY, 0, 0);
    `CHK(q, 32'h42dc_0000)
    op(OFS_CODE3, NO_KEY, 12'h200, 3, 0);
    bus(40'hff_ffff_fe80, 1, 32'h0000_0fff);
    bus(40'hff_ffff_fe80, 0, 0);
    `CHK({r, q}, {2'b11, 32'h0000_0000})
    bus(OFS_KEY, 1, KEY_ONE);
    pulse(0, 1);
    wait_idle(0);
    bus(OFS_KEY, 0, 0);
    `CHK(q, 32'h0000_0000)
    pulse(0, 0);
    bus(OFS_KEY, 1, KEY_ONE);
    pulse(4, 1);
    wait_idle(4);
    pulse(4, 0);
    test_done();
  end
endmodule : tb_flash_erase_interlock_control
